//--- verilog/fag_defines.vh
`ifndef FAG_DEFINES_VH
`define FAG_DEFINES_VH
// Control register indices (word index, byte offset / 2)
`define FAG_REG_CTL1      2'h0
`define FAG_REG_CTL2      2'h1
`define FAG_REG_CTL3      2'h2
`define FAG_REG_CTL4      2'h3
// Password bytes
`define FAG_KEY_WRITE     8'hA5
`define FAG_KEY_READ      8'h96
// Self-jump opcode served while flash is unreadable
`define FAG_SELF_JUMP     16'h3FFF
// Control 1 fields
`define FAG_C1_BLOCK_WRITE_SELECT     7
`define FAG_C1_WRT        6
`define FAG_C1_SWRT       5
`define FAG_C1_MERAS      2
`define FAG_C1_ERASE      1
`define FAG_C1_MASK       8'hE6
// Control 3 fields
`define FAG_C3_LOCKA      6
`define FAG_C3_EMERGENCY_EXIT_BIT       5
`define FAG_C3_LOCK       4
`define FAG_C3_WAIT       3
`define FAG_C3_ACCV       2
`define FAG_C3_PASSWORD_VIOLATION_FLAG       1
`define FAG_C3_BUSY       0
// Control 4 fields
`define FAG_C4_LOCKINFO   7
`define FAG_C4_MARGIN_READ_ONE       5
`define FAG_C4_MARGIN_READ_ZERO       4
`define FAG_C4_VPE        0
`define FAG_C4_MASK       8'hB0
// Write mode codes (block-write, write)
`define FAG_WM_RSVD       2'h0
`define FAG_WM_WORD       2'h1
`define FAG_WM_LONG       2'h2
`define FAG_WM_BLOCK      2'h3
// Erase mode codes (mass, erase)
`define FAG_EM_NONE       2'h0
`define FAG_EM_SEGMENT    2'h1
`define FAG_EM_BANK       2'h2
`define FAG_EM_MASS       2'h3
`endif

//--- verilog/fag_controller.v
// Behaviour
// [RULE1] CPU flash write while RAM-op busy violates
// [RULE2] Write without selected mode sets violation
// [RULE3] Flash-started write stalls fetch until idle
// [RULE4] Bank erase: erased bank reads 3FFF
// [RULE5] Bank erase: erased bank fetches 3FFF
// [RULE6] Bank erase: writes dropped, violation set
// [RULE7] Segment erase or write: 3FFF, writes violate
// [RULE8] Block wait=0 access aborts, locks, violates
// [RULE9] Block wait=1: reads 3FFF, writes accepted
// [RULE10] Interrupts suppressed while operation in progress
// [RULE11] Emergency exit aborts, clears control, locks
// [RULE12] Emergency exit for RAM ops, busy clears
// [RULE13] Bank erase from other bank exitable
// [RULE14] Margin read one/zero; one wins if both
// [RULE15] Margin read off during fetches
// [RULE16] CPU uses word access with key
// [RULE17] Bad key sets password flag, soft reset
// [RULE18] Control reads return 96 upper byte
// [RULE19] Control-1 write while busy violates, block exception
// [RULE20] Control-2 write busy violates; reads never do
// [RULE21] Enabled violation flag requests NMI, sticky
// [RULE22] Software runs block writes from RAM
// [RULE23] Write mode decode 00/01/10/11
// [RULE24] Lock during block wait=1 ends block normally
// [RULE25] Locked controller rejects program and erase
`timescale 1ns/1ps
`include "fag_defines.vh"

module fag_controller #(
    parameter ADDR_W = 16
) (
    // Clock, reset, enable
    input  wire              CLK,
    input  wire              RST_N,
    input  wire              CE,
    // Control register port (word accesses)
    input  wire              REG_WR,
    input  wire              REG_RD,
    input  wire [1:0]        REG_IDX,
    input  wire [15:0]       REG_WDATA,
    output reg  [15:0]       REG_RDATA,
    // CPU flash access
    input  wire              FL_RD,
    input  wire              FL_WR,
    input  wire              FL_FETCH,
    input  wire              FL_FROM_FLASH,
    input  wire              FL_CODE_IN_ERASED_BANK,
    input  wire              FL_IN_ERASED_BANK,
    input  wire [15:0]       FL_WDATA,
    input  wire [15:0]       ARRAY_RDATA,
    output reg  [15:0]       FL_RDATA,
    output wire              CPU_STALL,
    // Flash array engine
    output wire              PROG_START,
    output reg  [15:0]       PROG_DATA,
    output wire [1:0]        WRITE_MODE,
    output wire [1:0]        ERASE_MODE,
    output wire              ENGINE_ABORT,
    output wire              MARGIN_READ_ONE,
    output wire              MARGIN_READ_ZERO,
    input  wire              ENGINE_DONE,
    input  wire              ENGINE_WORD_READY,
    input  wire              VOLTAGE_ERROR,
    // System side
    input  wire              VIOLATION_IRQ_ENABLE,
    output wire              NMI_REQ,
    output wire              IRQ_SUPPRESS,
    output reg               SYSTEM_SOFT_RESET,
    output wire              BUSY,
    output wire              WAIT_READY
);

    ////////////////////////////////////////////////////////////////////////
    // Operation states
    localparam [2:0] ST_IDLE  = 3'h1;
    localparam [2:0] ST_BUSY  = 3'h2;
    localparam [2:0] ST_ABORT = 3'h4;

    reg [2:0] state;
    reg [7:0] ctl1;
    reg       lock_a;
    reg       lock;
    reg       wait_rdy;
    reg       access_violation_flag;
    reg       password_violation_flag;
    reg [7:0] ctl4;
    reg       from_flash;

    // Mode field decode, used for access classification and engine outputs
    function [1:0] fld;
        input [7:0] c;
        input integer hi;
        begin
            fld = {c[hi], c[hi - 3'h1]};
        end
    endfunction

    wire [1:0] wmode   = fld(ctl1, `FAG_C1_BLOCK_WRITE_SELECT);  // [RULE23]
    wire [1:0] emode   = fld(ctl1, `FAG_C1_MERAS);
    wire       busy    = (state != ST_IDLE);
    wire       blk     = busy && (wmode == `FAG_WM_BLOCK) && (emode == `FAG_EM_NONE);
    wire       bank_er = busy && (emode == `FAG_EM_BANK);
    wire       key_ok  = (REG_WDATA[15:8] == `FAG_KEY_WRITE);
    wire       exit_ok = !from_flash || (bank_er && !FL_CODE_IN_ERASED_BANK);

    ////////////////////////////////////////////////////////////////////////
    // Access classification
    reg        viol;
    reg        blk_abort;
    reg        wr_accept;
    reg        start;
    always @* begin
        viol      = 1'b0;
        blk_abort = 1'b0;
        wr_accept = 1'b0;
        start     = 1'b0;
        if (FL_WR && !busy) begin
            if (wmode == `FAG_WM_RSVD && emode == `FAG_EM_NONE)
                viol = 1'b1;                                  // [RULE2]
            else if (!lock)
                start = 1'b1;                                 // [RULE25]
        end
        if (busy && blk) begin
            if (!wait_rdy && (FL_RD || FL_WR || FL_FETCH)) begin
                viol      = 1'b1;                             // [RULE8]
                blk_abort = 1'b1;
            end else if (wait_rdy && FL_FETCH) begin
                viol      = 1'b1;                             // [RULE8]
                blk_abort = 1'b1;
            end else if (wait_rdy && FL_WR) begin
                wr_accept = 1'b1;                             // [RULE9]
            end
        end else if (busy && FL_WR) begin
            viol = 1'b1;                                      // [RULE1] [RULE6] [RULE7]
        end
        if (REG_WR && key_ok && busy) begin
            if (REG_IDX == `FAG_REG_CTL1 && !(blk && wait_rdy))
                viol = 1'b1;                                  // [RULE19]
            if (REG_IDX == `FAG_REG_CTL2)
                viol = 1'b1;                                  // [RULE20]
        end
    end

    wire emergency_exit_bit_wr = REG_WR && key_ok && REG_IDX == `FAG_REG_CTL3
                   && REG_WDATA[`FAG_C3_EMERGENCY_EXIT_BIT] && exit_ok;
    wire lock_end = REG_WR && key_ok && REG_IDX == `FAG_REG_CTL3
                    && REG_WDATA[`FAG_C3_LOCK] && blk && wait_rdy;

    ////////////////////////////////////////////////////////////////////////
    // Control state and sequencing
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state                   <= ST_IDLE;
            ctl1                    <= 8'h00;
            lock_a                  <= 1'b1;
            lock                    <= 1'b1;
            wait_rdy                <= 1'b1;
            access_violation_flag   <= 1'b0;
            password_violation_flag <= 1'b0;
            ctl4                    <= 8'h00;
            from_flash              <= 1'b0;
            SYSTEM_SOFT_RESET       <= 1'b0;
            PROG_DATA               <= 16'h0000;
        end else if (CE) begin
            SYSTEM_SOFT_RESET <= 1'b0;
            // Register writes with a bad key only flag and reset
            if (REG_WR && !key_ok) begin
                password_violation_flag <= 1'b1;              // [RULE17]
                SYSTEM_SOFT_RESET       <= 1'b1;              // [RULE17]
            end else if (REG_WR) begin
                case (REG_IDX)
                    `FAG_REG_CTL1: if (!busy || (blk && wait_rdy))
                        ctl1 <= REG_WDATA[7:0] & `FAG_C1_MASK; // [RULE19]
                    `FAG_REG_CTL3: begin
                        if (REG_WDATA[`FAG_C3_LOCKA])
                            lock_a <= ~lock_a;
                        lock <= REG_WDATA[`FAG_C3_LOCK];
                        if (!REG_WDATA[`FAG_C3_PASSWORD_VIOLATION_FLAG])
                            password_violation_flag <= 1'b0;
                    end
                    `FAG_REG_CTL4:
                        ctl4 <= (REG_WDATA[7:0] & `FAG_C4_MASK) | {7'h00, ctl4[`FAG_C4_VPE]
                                & REG_WDATA[`FAG_C4_VPE]};
                    default: ;
                endcase
            end
            // Software clear of the sticky flag; a same-cycle event wins
            if (REG_WR && key_ok && REG_IDX == `FAG_REG_CTL3 && !REG_WDATA[`FAG_C3_ACCV])
                access_violation_flag <= 1'b0;
            if (viol || VOLTAGE_ERROR)
                access_violation_flag <= 1'b1;                // [RULE21]
            if (VOLTAGE_ERROR)
                ctl4[`FAG_C4_VPE] <= 1'b1;
            // Fetch turns margin mode off
            if (FL_FETCH && !FL_RD)
                ctl4[`FAG_C4_MARGIN_READ_ONE:`FAG_C4_MARGIN_READ_ZERO] <= 2'h0;      // [RULE15]
            if (start || wr_accept)
                PROG_DATA <= FL_WDATA;
            case (state)
                ST_IDLE: begin
                    if (start) begin
                        state      <= ST_BUSY;
                        from_flash <= FL_FROM_FLASH;
                        wait_rdy   <= 1'b0;
                    end
                end
                ST_BUSY: begin
                    if (emergency_exit_bit_wr || blk_abort) begin
                        state <= ST_ABORT;                    // [RULE11] [RULE13]
                        ctl1  <= 8'h00;
                        lock  <= 1'b1;                        // [RULE8]
                    end else if (lock_end) begin
                        state    <= ST_IDLE;                  // [RULE24]
                        ctl1[`FAG_C1_BLOCK_WRITE_SELECT] <= 1'b0;
                        wait_rdy <= 1'b0;
                    end else if (ENGINE_DONE && !blk) begin
                        state <= ST_IDLE;
                        ctl1[`FAG_C1_MERAS:`FAG_C1_ERASE] <= `FAG_EM_NONE;
                        wait_rdy <= 1'b1;
                    end else if (blk) begin
                        if (wr_accept)
                            wait_rdy <= 1'b0;
                        else if (ENGINE_WORD_READY)
                            wait_rdy <= 1'b1;
                        if (ENGINE_DONE && !ctl1[`FAG_C1_BLOCK_WRITE_SELECT])
                            state <= ST_IDLE;
                    end
                end
                ST_ABORT: begin
                    if (ENGINE_DONE) begin
                        state    <= ST_IDLE;                  // [RULE12]
                        wait_rdy <= 1'b1;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data paths
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 16'h0000;
            FL_RDATA  <= 16'h0000;
        end else if (CE) begin
            if (REG_RD) begin
                case (REG_IDX)
                    `FAG_REG_CTL1: REG_RDATA <= {`FAG_KEY_READ, ctl1};        // [RULE18]
                    `FAG_REG_CTL3: REG_RDATA <= {`FAG_KEY_READ, 1'b0, lock_a, 1'b0,
                                                 lock, wait_rdy, access_violation_flag,
                                                 password_violation_flag, busy}; // [RULE20]
                    `FAG_REG_CTL4: REG_RDATA <= {`FAG_KEY_READ, ctl4};
                    default:       REG_RDATA <= {`FAG_KEY_READ, 8'h00};
                endcase
            end
            if (FL_RD || FL_FETCH) begin
                if (bank_er && !FL_IN_ERASED_BANK)
                    FL_RDATA <= ARRAY_RDATA;                  // [RULE4] [RULE5]
                else if (busy)
                    FL_RDATA <= `FAG_SELF_JUMP;               // [RULE4] [RULE5] [RULE7] [RULE9]
                else
                    FL_RDATA <= ARRAY_RDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // Flash-started work holds the CPU; a bank erase from another bank runs on
    assign CPU_STALL        = busy && from_flash && !(bank_er && !FL_CODE_IN_ERASED_BANK); // [RULE3]
    assign PROG_START       = start || wr_accept;
    assign WRITE_MODE       = wmode;
    assign ERASE_MODE       = emode;
    assign ENGINE_ABORT     = (state == ST_ABORT);           // [RULE11]
    assign MARGIN_READ_ONE  = ctl4[`FAG_C4_MARGIN_READ_ONE] && !FL_FETCH;                       // [RULE14]
    assign MARGIN_READ_ZERO = ctl4[`FAG_C4_MARGIN_READ_ZERO] && !ctl4[`FAG_C4_MARGIN_READ_ONE] && !FL_FETCH; // [RULE14]
    assign NMI_REQ          = access_violation_flag && VIOLATION_IRQ_ENABLE; // [RULE21]
    assign IRQ_SUPPRESS     = busy;                           // [RULE10]
    assign BUSY             = busy;
    assign WAIT_READY       = wait_rdy;

endmodule

//--- tb/fag_assertions.sv
`timescale 1ns/1ps
`include "fag_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module fag_checker (
    // Clock and register port
    input wire        CLK, RST_N, CE, REG_WR, REG_RD,
    input wire [1:0]  REG_IDX,
    input wire [15:0] REG_WDATA, REG_RDATA,
    // Flash access and engine
    input wire        FL_RD, FL_WR, FL_FETCH, FL_FROM_FLASH, FL_IN_ERASED_BANK,
    input wire [15:0] ARRAY_RDATA, FL_RDATA,
    input wire [1:0]  WRITE_MODE, ERASE_MODE,
    input wire        PROG_START, MARGIN_READ_ONE, MARGIN_READ_ZERO, WAIT_READY,
    // System side
    input wire        BUSY, VIOLATION_IRQ_ENABLE, NMI_REQ, IRQ_SUPPRESS, SYSTEM_SOFT_RESET
);
    // Register writes with and without the right key
    wire ok_wr  = CE && REG_WR && REG_WDATA[15:8] == `FAG_KEY_WRITE;
    wire bad_wr = CE && REG_WR && REG_WDATA[15:8] != `FAG_KEY_WRITE;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    read_key_a: assert property (CE && REG_RD |=> REG_RDATA[15:8] == `FAG_KEY_READ)
        else $error("read key byte wrong");
    bad_key_reset_a: assert property (bad_wr |=> SYSTEM_SOFT_RESET)
        else $error("no soft reset on bad key");
    reset_cause_a: assert property (SYSTEM_SOFT_RESET |-> $past(bad_wr))
        else $error("soft reset without bad key");
    irq_hold_a: assert property (CE && PROG_START |=> IRQ_SUPPRESS && BUSY)
        else $error("interrupts not held during operation");
    nmi_gate_a: assert property (NMI_REQ |-> VIOLATION_IRQ_ENABLE)
        else $error("NMI request while disabled");
    margin_one_a: assert property (!(MARGIN_READ_ONE && MARGIN_READ_ZERO))
        else $error("both margin modes on");
    fetch_margin_a: assert property (CE && FL_FETCH && !REG_WR
        |=> !MARGIN_READ_ONE && !MARGIN_READ_ZERO) else $error("margin on after fetch");
    seg_read_a: assert property (CE && FL_RD && BUSY && ERASE_MODE != `FAG_EM_BANK
        |=> FL_RDATA == `FAG_SELF_JUMP) else $error("busy read not self-jump");
    bank_read_a: assert property (CE && FL_RD && BUSY && ERASE_MODE == `FAG_EM_BANK
        |=> FL_RDATA == ($past(FL_IN_ERASED_BANK) ? `FAG_SELF_JUMP : $past(ARRAY_RDATA)))
        else $error("bank erase read wrong");
    erase_drop_a: assert property (CE && FL_WR && BUSY && ERASE_MODE != `FAG_EM_NONE
        |-> !PROG_START) else $error("write accepted during erase");
    blk_accept_a: assert property (CE && FL_WR && BUSY && WAIT_READY
        && WRITE_MODE == `FAG_WM_BLOCK |-> PROG_START) else $error("block word refused");
    emergency_exit_bit_clear_a: assert property (ok_wr && REG_IDX == `FAG_REG_CTL3
        && REG_WDATA[`FAG_C3_EMERGENCY_EXIT_BIT] && BUSY && !FL_FROM_FLASH
        |-> ##[1:4] (WRITE_MODE == 2'h0 && ERASE_MODE == 2'h0)) else $error("exit kept modes");
endmodule
bind fag_controller fag_checker i_chk (.*);

//--- tb/fag_engine_model.sv
`timescale 1ns/1ps
`include "fag_defines.vh"
////////////////////////////////////////////////////////////////////////////////
module fag_engine_model #(
    parameter [7:0] LAT = 8'h28
) (
    // Clock and reset
    input  wire        CLK,
    input  wire        RST_N,
    // Requests from the controller
    input  wire        PROG_START,
    input  wire        ENGINE_ABORT,
    input  wire [1:0]  WRITE_MODE,
    // Answers to the controller
    output reg         ENGINE_DONE,
    output reg         ENGINE_WORD_READY,
    output wire [15:0] ARRAY_RDATA
);
    reg [7:0] cnt;
    reg       run;
    reg       blk;
    // Fixed array content keeps read expectations simple
    assign ARRAY_RDATA = 16'h5A3C;
    // One operation at a time; a block ends on abort or once its select is dropped
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            {cnt, run, blk, ENGINE_DONE, ENGINE_WORD_READY} <= 12'h000;
        end else begin
            ENGINE_DONE <= 1'b0;
            ENGINE_WORD_READY <= 1'b0;
            if (ENGINE_ABORT && !ENGINE_DONE) begin
                {run, blk} <= 2'h0;
                ENGINE_DONE <= 1'b1; // Abort completes after one cycle
            end else if (PROG_START) begin
                run <= 1'b1;
                cnt <= LAT;
                blk <= WRITE_MODE == `FAG_WM_BLOCK;
            end else if (run && cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else if (run) begin
                run <= 1'b0;
                ENGINE_WORD_READY <= blk;
                ENGINE_DONE <= !blk;
            end else if (blk && WRITE_MODE != `FAG_WM_BLOCK) begin
                blk <= 1'b0;
                ENGINE_DONE <= 1'b1;
            end
        end
    end
endmodule

//--- tb/flash_access_guard_controller_test.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module flash_access_guard_controller_test;
    reg         CLK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, ps, sr;
    reg         FL_RD = 1'b0, FL_WR = 1'b0, FL_FETCH = 1'b0, FL_FROM_FLASH = 1'b0;
    reg         FL_CODE_IN_ERASED_BANK = 1'b0, FL_IN_ERASED_BANK = 1'b0, IRQ_EN = 1'b0;
    reg  [1:0]  REG_IDX = 2'h0;
    reg  [15:0] REG_WDATA = 16'h0000, FL_WDATA = 16'h1357;
    wire [15:0] REG_RDATA, FL_RDATA, PROG_DATA, ARRAY_RDATA;
    wire [1:0]  WRITE_MODE, ERASE_MODE;
    wire        CPU_STALL, PROG_START, ENGINE_ABORT, MARGIN_READ_ONE, MARGIN_READ_ZERO, BUSY;
    wire        ENGINE_DONE, ENGINE_WORD_READY, NMI_REQ, IRQ_SUPPRESS, SYSTEM_SOFT_RESET, WAIT_READY;
    integer     error_cnt = 0, n_checks = 0, k;
    // Controller under test and the engine on its far side
    fag_controller i_dut (.CLK(CLK), .RST_N(RST_N), .CE(1'b1), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_IDX(REG_IDX), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .FL_RD(FL_RD),
        .FL_WR(FL_WR), .FL_FETCH(FL_FETCH), .FL_FROM_FLASH(FL_FROM_FLASH),
        .FL_CODE_IN_ERASED_BANK(FL_CODE_IN_ERASED_BANK), .FL_IN_ERASED_BANK(FL_IN_ERASED_BANK),
        .FL_WDATA(FL_WDATA), .ARRAY_RDATA(ARRAY_RDATA), .FL_RDATA(FL_RDATA), .CPU_STALL(CPU_STALL),
        .PROG_START(PROG_START), .PROG_DATA(PROG_DATA), .WRITE_MODE(WRITE_MODE),
        .ERASE_MODE(ERASE_MODE), .ENGINE_ABORT(ENGINE_ABORT), .MARGIN_READ_ONE(MARGIN_READ_ONE),
        .MARGIN_READ_ZERO(MARGIN_READ_ZERO), .ENGINE_DONE(ENGINE_DONE),
        .ENGINE_WORD_READY(ENGINE_WORD_READY), .VOLTAGE_ERROR(1'b0),
        .VIOLATION_IRQ_ENABLE(IRQ_EN), .NMI_REQ(NMI_REQ), .IRQ_SUPPRESS(IRQ_SUPPRESS),
        .SYSTEM_SOFT_RESET(SYSTEM_SOFT_RESET), .BUSY(BUSY), .WAIT_READY(WAIT_READY));
    fag_engine_model #(.LAT(40)) i_eng (.CLK(CLK), .RST_N(RST_N), .PROG_START(PROG_START),
        .ENGINE_ABORT(ENGINE_ABORT), .WRITE_MODE(WRITE_MODE), .ENGINE_DONE(ENGINE_DONE),
        .ENGINE_WORD_READY(ENGINE_WORD_READY), .ARRAY_RDATA(ARRAY_RDATA));
    initial forever #5 CLK = ~CLK;
    // Compare and count; four-state compare so unknowns never match
    task chk(input [79:0] nm, input [15:0] seen, input [15:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("Error %0s: expected %h, seen %h", nm, exp, seen);
            end
        end
    endtask
    // Strobes last one cycle; a spare cycle follows so no strobe is set twice at once
    task wreg(input [1:0] idx, input [15:0] d);
        begin
            REG_IDX = idx;
            REG_WDATA = d; // Word access, key in the upper byte
            REG_WR = 1'b1;
            @(negedge CLK) REG_WR = 1'b0;
            sr = SYSTEM_SOFT_RESET;
            @(negedge CLK);
        end
    endtask
    task rd(input [1:0] idx, input [15:0] exp, input [15:0] msk);
        begin
            REG_IDX = idx;
            REG_RD = 1'b1;
            @(negedge CLK) REG_RD = 1'b0;
            chk("control", REG_RDATA & msk, exp);
            @(negedge CLK);
        end
    endtask
    task acc(input r, input w, input f);
        begin
            {FL_RD, FL_WR, FL_FETCH} = {r, w, f};
            #1 ps = PROG_START;
            @(negedge CLK) {FL_RD, FL_WR, FL_FETCH} = 3'h0;
            @(negedge CLK);
        end
    endtask
    // Bounded wait for ready (sel=1) or for idle (sel=0)
    task hold(input sel);
        begin
            for (k = 0; k < 200 && (sel ? WAIT_READY !== 1'b1 : BUSY !== 1'b0); k = k + 1)
                @(negedge CLK);
            chk("wait", k < 200, 16'h0001);
        end
    endtask
    task test_done;
        begin
            $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
            if (error_cnt == 0 && n_checks > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Run is a few hundred cycles; the watchdog allows 10000 cycles, over twenty times that
    initial begin
        #100000 error_cnt = error_cnt + 1;
        test_done;
    end
    initial begin
        repeat (16) @(negedge CLK);
        RST_N = 1'b1;
        rd(2, 16'h9658, 16'hFFFF);
        rd(0, 16'h9600, 16'hFFFF);
        wreg(2, 16'h5A00);
        chk("softreset", sr, 16'h0001);
        rd(2, 16'h965A, 16'hFFFF);
        wreg(2, 16'hA500);
        IRQ_EN = 1'b1;
        acc(0, 1, 0);
        chk("start", ps, 16'h0000);
        rd(2, 16'h964C, 16'hFFFF);
        chk("nmi", NMI_REQ, 16'h0001);
        IRQ_EN = 1'b0;
        #1 chk("nmi", NMI_REQ, 16'h0000);
        wreg(2, 16'hA500);
        rd(2, 16'h9648, 16'hFFFF);
        $display("Test 1 done");
        // Word write from RAM; violations while busy
        wreg(0, 16'hA540);
        acc(0, 1, 0);
        chk("start", ps, 16'h0001);
        chk("irqsup", IRQ_SUPPRESS, 16'h0001);
        acc(1, 0, 0);
        chk("rdata", FL_RDATA, 16'h3FFF);
        rd(2, 16'h9601, 16'hFF05);
        wreg(1, 16'hA500);
        rd(2, 16'h9605, 16'hFF05);
        wreg(2, 16'hA500);
        acc(0, 1, 0);
        chk("start", ps, 16'h0000);
        rd(2, 16'h9605, 16'hFF05);
        wreg(2, 16'hA500);
        wreg(0, 16'hA540);
        rd(2, 16'h9605, 16'hFF05);
        hold(0);
        chk("irqsup", IRQ_SUPPRESS, 16'h0000);
        wreg(2, 16'hA500);
        // Write from flash stalls the waiting fetch until idle
        FL_FROM_FLASH = 1'b1;
        acc(0, 1, 0);
        FL_FETCH = 1'b1;
        #1 chk("stall", CPU_STALL, 16'h0001);
        hold(0);
        chk("stall", CPU_STALL, 16'h0000);
        @(negedge CLK) {FL_FETCH, FL_FROM_FLASH} = 2'h0;
        @(negedge CLK);
        // Segment erase from RAM: reads self-jump, writes violate
        wreg(0, 16'hA502);
        acc(0, 1, 0);
        acc(1, 0, 0);
        chk("rdata", FL_RDATA, 16'h3FFF);
        acc(0, 1, 0);
        rd(2, 16'h9605, 16'hFF05);
        hold(0);
        wreg(2, 16'hA500);
        $display("Test 2 done");
        // Bank erase reads, fetches, write and emergency exit
        wreg(0, 16'hA504);
        acc(0, 1, 0);
        {FL_CODE_IN_ERASED_BANK, FL_IN_ERASED_BANK} = 2'h3;
        acc(1, 0, 0);
        chk("rdata", FL_RDATA, 16'h3FFF);
        acc(0, 0, 1);
        chk("fetch", FL_RDATA, 16'h3FFF);
        {FL_CODE_IN_ERASED_BANK, FL_IN_ERASED_BANK} = 2'h0;
        acc(1, 0, 0);
        chk("rdata", FL_RDATA, 16'h5A3C);
        acc(0, 1, 0);
        chk("start", ps, 16'h0000);
        wreg(2, 16'hA524);
        chk("abort", ENGINE_ABORT, 16'h0001);
        @(negedge CLK);
        chk("busy", BUSY, 16'h0000);
        rd(0, 16'h9600, 16'hFFFF);
        rd(2, 16'h965C, 16'hFFDF);
        // Bank erase started from flash, code in another bank: exit honoured
        FL_FROM_FLASH = 1'b1;
        wreg(2, 16'hA500);
        wreg(0, 16'hA504);
        acc(0, 1, 0);
        FL_FROM_FLASH = 1'b0;
        chk("stall", CPU_STALL, 16'h0000);
        wreg(2, 16'hA524);
        chk("abort", ENGINE_ABORT, 16'h0001);
        hold(0);
        $display("Test 3 done");
        // Block write from RAM, then an access while not ready aborts it
        wreg(2, 16'hA500);
        wreg(0, 16'hA5C0);
        acc(0, 1, 0);
        chk("start", ps, 16'h0001);
        hold(1);
        acc(1, 0, 0);
        chk("rdata", FL_RDATA, 16'h3FFF);
        rd(2, 16'h9608, 16'hFF0C);
        FL_WDATA = 16'h2468;
        acc(0, 1, 0);
        chk("start", ps, 16'h0001);
        chk("pdata", PROG_DATA, 16'h2468);
        acc(1, 0, 0);
        hold(0);
        rd(2, 16'h9614, 16'hFF14);
        // Locking while ready ends the block normally
        wreg(2, 16'hA500);
        wreg(0, 16'hA5C0);
        acc(0, 1, 0);
        hold(1);
        wreg(2, 16'hA510);
        chk("busy", BUSY, 16'h0000);
        rd(2, 16'h9610, 16'hFF19);
        wreg(0, 16'hA540);
        acc(0, 1, 0);
        chk("start", ps, 16'h0000);
        chk("busy", BUSY, 16'h0000);
        $display("Test 4 done");
        // Margin modes: one wins, a fetch turns both off
        wreg(3, 16'hA530);
        chk("margin", {MARGIN_READ_ONE, MARGIN_READ_ZERO}, 16'h0002);
        rd(3, 16'h9630, 16'hFFFF);
        acc(0, 0, 1);
        chk("margin", {MARGIN_READ_ONE, MARGIN_READ_ZERO}, 16'h0000);
        $display("Test 5 done");
        test_done;
    end
endmodule
